// ==== src/adc_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// conversion-clock enable from bus clock or async tick, divided 1/2/4/8
module adc_clk_div (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic [1:0] iclk_i,
   input wire logic [1:0] div_i,
   input wire logic async_tick_i,
   input wire logic run_i,
   // output
   output logic tick_o
);
   import adc_ctrl_pkg::*;
   logic [2:0] cnt_reg;
   logic src_tick;
   logic [2:0] lim;
   logic half_reg;
   always_comb begin
      unique case (iclk_i)
         CLK_BUS: src_tick = 1'b1;
         CLK_BUS_DIV2: src_tick = half_reg;
         default: src_tick = async_tick_i;
      endcase
      lim = 3'((4'h1 << div_i) - 4'h1);
   end
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         half_reg <= 1'b0;
      end else begin
         half_reg <= ~half_reg;
      end
   end
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg <= 3'h0;
      end else if (!run_i) begin
         cnt_reg <= 3'h0;
      end else if (src_tick) begin
         cnt_reg <= (cnt_reg >= lim) ? 3'h0 : 3'(cnt_reg + 3'h1);
      end
   end
   assign tick_o = run_i && src_tick && (cnt_reg >= lim);
endmodule : adc_clk_div
`default_nettype wire

// ==== src/adc_ctrl_pkg.sv ====
// How it works
// - stop3 without async clock aborts to idle
// - stop3 entry/exit keeps result registers
// - after stop3 abort wait fresh trigger
// - async clock selected keeps running in stop3
// - running conversion completes; stop3 starts by trigger/continuous
// - completion in stop3 sets flag, wakes if enabled
// - stop1/stop2 disables, registers reset
// - configuration field layout bits 7..0
// - mode 10 ten-bit, clock 00 bus, divide 00
// - status two: active, trigger, compare, greater
// - status two bits 3:0 read zero
// - status one: complete, irq enable, continuous, channel
// - single conversion; channel code selects input
// - pin control bit disables digital io only
// - saturate to full-scale or zero codes
// - sample 3.5 or 23.5 conversion-clock cycles; code samples 4 or 24 whole ticks
// - status one write aborts, restarts unless all ones or hardware trigger selected
// - 10-bit mode: high read, low unread discards new result
// - compare gates flag and transfer
package adc_ctrl_pkg;
   localparam logic [3:0] ADDR_CFG = 4'h0;
   localparam logic [3:0] ADDR_SC2 = 4'h1;
   localparam logic [3:0] ADDR_SC1 = 4'h2;
   localparam logic [3:0] ADDR_RES_HI = 4'h3;
   localparam logic [3:0] ADDR_RES_LO = 4'h4;
   localparam logic [3:0] ADDR_CMP_HI = 4'h5;
   localparam logic [3:0] ADDR_CMP_LO = 4'h6;
   localparam logic [3:0] ADDR_PIN_ONE = 4'h7;
   localparam logic [3:0] ADDR_PIN_TWO = 4'h8;
   localparam int BIT_LP = 7;
   localparam int BIT_DIV_HI = 6;
   localparam int BIT_DIV_LO = 5;
   localparam int BIT_LSMP = 4;
   localparam int BIT_MODE_HI = 3;
   localparam int BIT_MODE_LO = 2;
   localparam int BIT_ACT = 7;
   localparam int BIT_TRG = 6;
   localparam int BIT_CFE = 5;
   localparam int BIT_CFGT = 4;
   localparam int BIT_CONV_COMPLETE_FLAG = 7;
   localparam int BIT_IEN = 6;
   localparam int BIT_CONT = 5;
   localparam logic [1:0] MODE_8 = 2'h0;
   localparam logic [1:0] MODE_10 = 2'h2;
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
   localparam logic [1:0] CLK_ASYNC = 2'h3;
   localparam logic [4:0] CH_OFF = 5'h1F;
   localparam logic [7:0] SC2_WMASK = 8'h70;
   localparam logic [7:0] SC1_WMASK = 8'h7F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [9:0] FULL_10 = 10'h3FF;
   localparam logic [9:0] FULL_8 = 10'h0FF;
   localparam logic [9:0] ZERO_CODE = 10'h000;
   // half cycles: 3.5 and 23.5 conversion-clock cycles
   localparam int SAMPLE_SHORT_HALVES = 7;
   localparam int SAMPLE_LONG_HALVES = 47;
   localparam logic [5:0] SAMPLE_SHORT_CNT = 6'(SAMPLE_SHORT_HALVES);
   localparam logic [5:0] SAMPLE_LONG_CNT = 6'(SAMPLE_LONG_HALVES);
   localparam logic [5:0] SAMPLE_STEP = 6'h2;
   // whole ticks that cover the half-cycle windows
   localparam logic [5:0] SAMPLE_SHORT_TICKS = 6'h04;
   localparam logic [5:0] SAMPLE_LONG_TICKS = 6'h18;
   localparam logic [3:0] BITS_10 = 4'hA;
   localparam logic [3:0] BITS_8 = 4'h8;
   typedef struct packed {
      logic lp;
      logic [1:0] div;
      logic lsmp;
      logic [1:0] mode;
      logic [1:0] iclk;
   } cfg_t;
   typedef struct packed {
      logic ien;
      logic cont;
      logic [4:0] ch;
   } sc1_t;
   typedef struct packed {
      logic trg;
      logic cfe;
      logic cfgt;
   } sc2_t;
   typedef struct packed {
      logic [1:0] run_stop;
      logic stop3;
      logic deep_stop;
   } pwr_t;
endpackage : adc_ctrl_pkg

// ==== src/adc_low_power_mode_control.sv ====
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adc_low_power_mode_control (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // power mode and triggers
   input wire adc_ctrl_pkg::pwr_t pwr_i,
   input wire logic hw_trig_i,
   input wire logic async_tick_i,
   // analog front end
   input wire logic cmp_hi_i,
   input wire logic at_high_ref_i,
   input wire logic at_low_ref_i,
   output logic [9:0] dac_trial_o,
   output logic sampling_o,
   output logic [4:0] channel_o,
   output logic [15:0] pin_dig_disable_o,
   // status
   output logic irq_o,
   output logic wake_o
);
   import adc_ctrl_pkg::*;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } state_t;
   state_t state_reg;
   cfg_t cfg_reg;
   sc1_t sc1_reg;
   sc2_t sc2_reg;
   logic conv_complete_flag_reg;
   logic [9:0] res_reg;
   logic [9:0] cmp_reg;
   logic [7:0] pin_one_reg;
   logic [7:0] pin_two_reg;
   logic hi_read_reg;
   logic [5:0] samp_reg;
   logic [1:0] stop3_sync_reg;
   logic [1:0] deep_sync_reg;
   logic [1:0] trig_sync_reg;
   logic stop3;
   logic deep;
   logic trig_rise;
   logic trig_prev_reg;
   logic async_sel;
   logic tick;
   logic sar_start;
   logic sar_done;
   logic sar_busy;
   logic [9:0] sar_code;
   logic [9:0] diff;
   logic cmp_ok;
   logic blocked;
   logic halt_stop3;
   logic wr_sc1;
   logic wr_mode;
   logic start_req;
   logic abort;
   logic soft_rst;
   logic ten_bit;
   logic [5:0] samp_lim;

   // pin inputs through two flops
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stop3_sync_reg <= 2'b00;
         deep_sync_reg <= 2'b00;
         trig_sync_reg <= 2'b00;
         trig_prev_reg <= 1'b0;
      end else begin
         stop3_sync_reg <= {stop3_sync_reg[0], pwr_i.stop3};
         deep_sync_reg <= {deep_sync_reg[0], pwr_i.deep_stop};
         trig_sync_reg <= {trig_sync_reg[0], hw_trig_i};
         trig_prev_reg <= trig_sync_reg[1];
      end
   end
   assign stop3 = stop3_sync_reg[1];
   assign deep = deep_sync_reg[1];
   assign trig_rise = trig_sync_reg[1] && !trig_prev_reg;
   assign soft_rst = deep;
   assign async_sel = (cfg_reg.iclk == CLK_ASYNC);
   assign ten_bit = (cfg_reg.mode == MODE_10);
   // without async clock the converter is held idle in stop3
   assign halt_stop3 = stop3 && !async_sel;

   assign wr_sc1 = wr_i && (addr_i == ADDR_SC1);
   assign wr_mode = wr_i && (addr_i == ADDR_SC2 || addr_i == ADDR_CFG
      || addr_i == ADDR_CMP_HI || addr_i == ADDR_CMP_LO);
   // in stop3 the cpu is halted, so only hardware or continuous starts
   assign start_req = (wr_sc1 && !sc2_reg.trg && wdata_i[4:0] != CH_OFF)
      || (sc2_reg.trg && trig_rise && sc1_reg.ch != CH_OFF);
   assign abort = wr_sc1 || wr_mode || halt_stop3 || soft_rst;

   // compare difference; result minus compare value
   assign diff = 10'(sar_code - cmp_reg);
   assign cmp_ok = !sc2_reg.cfe || (sc2_reg.cfgt ? (sar_code >= cmp_reg)
      : (sar_code < cmp_reg));
   assign blocked = ten_bit && hi_read_reg;

   assign samp_lim = cfg_reg.lsmp ? SAMPLE_LONG_CNT : SAMPLE_SHORT_CNT;

   adc_clk_div u_div (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .iclk_i(cfg_reg.iclk),
      .div_i(cfg_reg.div),
      .async_tick_i(async_tick_i),
      .run_i(state_reg != ST_IDLE),
      .tick_o(tick)
   );

   // the tick that completes the window hands over at once
   assign sar_start = (state_reg == ST_SAMPLE) && tick
      && (6'(samp_reg + SAMPLE_STEP) >= samp_lim);

   adc_sar_seq u_sar (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick),
      .start_i(sar_start),
      .abort_i(abort),
      .ten_bit_i(ten_bit),
      .cmp_hi_i(cmp_hi_i),
      .at_high_ref_i(at_high_ref_i),
      .at_low_ref_i(at_low_ref_i),
      .busy_o(sar_busy),
      .done_o(sar_done),
      .code_o(sar_code),
      .trial_o(dac_trial_o)
   );

   // conversion sequencing
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_IDLE;
         samp_reg <= 6'h00;
      end else if (soft_rst) begin
         state_reg <= ST_IDLE;
         samp_reg <= 6'h00;
      end else if (abort && !(wr_sc1 && start_req)) begin
         state_reg <= ST_IDLE;
         samp_reg <= 6'h00;
      end else if (start_req) begin
         state_reg <= ST_SAMPLE;
         samp_reg <= 6'h00;
      end else begin
         unique case (state_reg)
            ST_IDLE: samp_reg <= 6'h00;
            ST_SAMPLE: begin
               // counts half cycles: two per conversion-clock tick
               if (tick) begin
                  samp_reg <= 6'(samp_reg + SAMPLE_STEP);
               end
               if (sar_start) begin
                  state_reg <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (sar_done) begin
                  // blocked results retrigger; compare miss ends single mode
                  if (blocked && !(sc2_reg.cfe && !cmp_ok && !sc1_reg.cont)) begin
                     state_reg <= ST_SAMPLE;
                  end else if (sc1_reg.cont) begin
                     state_reg <= ST_SAMPLE;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
                  // every window starts empty, as long as the first
                  samp_reg <= 6'h00;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ticks seen in the sample window, for the length check
   logic [5:0] samp_ticks_reg;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         samp_ticks_reg <= 6'h00;
      end else if (state_reg != ST_SAMPLE || sar_start || start_req) begin
         samp_ticks_reg <= 6'h00;
      end else if (tick) begin
         samp_ticks_reg <= 6'(samp_ticks_reg + 6'h01);
      end
   end

   // results survive stop3 and aborts; only reset or deep stop clear them
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         res_reg <= ZERO_CODE;
         conv_complete_flag_reg <= 1'b0;
         hi_read_reg <= 1'b0;
      end else if (soft_rst) begin
         res_reg <= ZERO_CODE;
         conv_complete_flag_reg <= 1'b0;
         hi_read_reg <= 1'b0;
      end else begin
         if (sar_done && cmp_ok && !blocked && !abort) begin
            res_reg <= sc2_reg.cfe ? diff : sar_code;
            conv_complete_flag_reg <= 1'b1;
         end else if (wr_sc1 || wr_mode || (rd_i && addr_i == ADDR_RES_LO)) begin
            conv_complete_flag_reg <= 1'b0;
         end
         if (rd_i && addr_i == ADDR_RES_HI) begin
            hi_read_reg <= 1'b1;
         end else if (rd_i && addr_i == ADDR_RES_LO) begin
            hi_read_reg <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_reg <= '0;
         sc1_reg <= '{ien: 1'b0, cont: 1'b0, ch: CH_OFF};
         sc2_reg <= '0;
         cmp_reg <= ZERO_CODE;
         pin_one_reg <= BYTE_ZERO;
         pin_two_reg <= BYTE_ZERO;
      end else if (soft_rst) begin
         cfg_reg <= '0;
         sc1_reg <= '{ien: 1'b0, cont: 1'b0, ch: CH_OFF};
         sc2_reg <= '0;
         cmp_reg <= ZERO_CODE;
         pin_one_reg <= BYTE_ZERO;
         pin_two_reg <= BYTE_ZERO;
      end else if (wr_i) begin
         unique case (addr_i)
            ADDR_CFG: cfg_reg <= cfg_t'(wdata_i);
            ADDR_SC1: sc1_reg <= sc1_t'(wdata_i[BIT_IEN:0]);
            ADDR_SC2: sc2_reg <= sc2_t'(wdata_i[BIT_TRG:BIT_CFGT]);
            ADDR_CMP_HI: cmp_reg[9:8] <= wdata_i[1:0];
            ADDR_CMP_LO: cmp_reg[7:0] <= wdata_i;
            ADDR_PIN_ONE: pin_one_reg <= wdata_i;
            ADDR_PIN_TWO: pin_two_reg <= wdata_i;
            default: ;
         endcase
      end
   end

   // read port: data in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= BYTE_ZERO;
      end else if (rd_i) begin
         unique case (addr_i)
            ADDR_CFG: rdata_o <= cfg_reg;
            ADDR_SC1: rdata_o <= {conv_complete_flag_reg, sc1_reg};
            ADDR_SC2: rdata_o <= {state_reg != ST_IDLE, sc2_reg, 4'h0};
            ADDR_RES_HI: rdata_o <= {6'h00, ten_bit ? res_reg[9:8] : 2'b00};
            ADDR_RES_LO: rdata_o <= ten_bit ? res_reg[7:0] : res_reg[7:0];
            ADDR_CMP_HI: rdata_o <= {6'h00, cmp_reg[9:8]};
            ADDR_CMP_LO: rdata_o <= cmp_reg[7:0];
            ADDR_PIN_ONE: rdata_o <= pin_one_reg;
            ADDR_PIN_TWO: rdata_o <= pin_two_reg;
            default: rdata_o <= BYTE_ZERO;
         endcase
      end else begin
         rdata_o <= BYTE_ZERO;
      end
   end

   assign sampling_o = (state_reg == ST_SAMPLE);
   assign channel_o = sc1_reg.ch;
   // analog use never needs the bit; it only shuts the digital buffer
   assign pin_dig_disable_o = {pin_two_reg, pin_one_reg};
   assign irq_o = conv_complete_flag_reg && sc1_reg.ien;
   assign wake_o = irq_o && stop3;

   a_irq_set: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      sar_done && cmp_ok && !blocked && !abort && sc1_reg.ien |=> irq_o)
      else $error("irq not raised");
   a_stop3_idle: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      halt_stop3 && !start_req |=> state_reg == ST_IDLE) else $error("no abort");
   a_result_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      !sar_done && !soft_rst |=> res_reg == $past(res_reg)) else $error("result moved");
   a_idle_stays: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      state_reg == ST_IDLE && !start_req |=> state_reg == ST_IDLE) else $error("self start");
   a_deep_reset: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      soft_rst |=> cfg_reg == '0 && !conv_complete_flag_reg) else $error("no deep reset");
   a_sc2_zeros: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rd_i && addr_i == ADDR_SC2 |=> rdata_o[3:0] == 4'h0) else $error("sc2 low bits");
   a_block_drop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      sar_done && blocked && !conv_complete_flag_reg && !wr_sc1 |=> !conv_complete_flag_reg) else $error("blocked set");
   a_cmp_gate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      sar_done && !cmp_ok && !soft_rst |=> res_reg == $past(res_reg))
      else $error("cmp transfer");
   a_async_runs: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      stop3 && async_sel && state_reg == ST_CONVERT && !sar_done && !wr_i && !soft_rst
      |=> state_reg != ST_IDLE) else $error("async run aborted");
   a_sample_len: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      sar_start |-> 6'(samp_ticks_reg + 6'h01)
      == (cfg_reg.lsmp ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS))
      else $error("sample length");
   a_sc1_restart: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_sc1 && !sc2_reg.trg && wdata_i[4:0] != CH_OFF && !soft_rst
      |=> state_reg == ST_SAMPLE && !sar_busy) else $error("no restart");
   a_sc1_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_sc1 && !start_req |=> state_reg == ST_IDLE) else $error("off channel started");
endmodule : adc_low_power_mode_control
`default_nettype wire

// ==== src/adc_sar_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
// successive approximation against comparator input, with end saturation
module adc_sar_seq (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic ten_bit_i,
   input wire logic cmp_hi_i,
   input wire logic at_high_ref_i,
   input wire logic at_low_ref_i,
   // result
   output logic busy_o,
   output logic done_o,
   output logic [9:0] code_o,
   output logic [9:0] trial_o
);
   import adc_ctrl_pkg::*;
   logic [3:0] bit_reg;
   logic [9:0] acc_reg;
   logic [9:0] full;
   logic [9:0] one_hot;
   assign full = ten_bit_i ? FULL_10 : FULL_8;
   assign one_hot = 10'(10'h001 << (bit_reg - 4'h1));
   assign trial_o = acc_reg | one_hot;
   assign busy_o = (bit_reg != 4'h0);
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bit_reg <= 4'h0;
         acc_reg <= ZERO_CODE;
         done_o <= 1'b0;
         code_o <= ZERO_CODE;
      end else begin
         done_o <= 1'b0;
         if (abort_i) begin
            bit_reg <= 4'h0;
         end else if (start_i) begin
            bit_reg <= ten_bit_i ? BITS_10 : BITS_8;
            acc_reg <= ZERO_CODE;
         end else if (busy_o && tick_i) begin
            if (cmp_hi_i) begin
               acc_reg <= trial_o;
            end
            bit_reg <= 4'(bit_reg - 4'h1);
            if (bit_reg == 4'h1) begin
               done_o <= 1'b1;
               if (at_high_ref_i) begin
                  code_o <= full;
               end else if (at_low_ref_i) begin
                  code_o <= ZERO_CODE;
               end else begin
                  code_o <= cmp_hi_i ? trial_o : acc_reg;
               end
            end
         end
      end
   end
endmodule : adc_sar_seq
`default_nettype wire

// ==== tb/adc_afe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// analog front end and async clock source
module adc_afe_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // stimulus
   input wire logic [9:0] target_i,
   input wire logic sat_hi_i,
   input wire logic sat_lo_i,
   input wire logic [9:0] trial_i,
   // to converter
   output logic cmp_hi_o,
   output logic at_high_ref_o,
   output logic at_low_ref_o,
   output logic async_tick_o
);
   logic [1:0] div_reg;
   // input sits half a step above target, so either trial reading gives target
   assign cmp_hi_o = target_i >= trial_i;
   assign at_high_ref_o = sat_hi_i;
   assign at_low_ref_o = sat_lo_i;
   // free running, one tick in three bus cycles
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      end
   end
   assign async_tick_o = div_reg == 2'h2;
endmodule : adc_afe_model
`default_nettype wire

// ==== tb/adc_low_power_mode_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module adc_low_power_mode_control_test;
   import adc_ctrl_pkg::*;
   logic core_clk_i, nrst_i, wr, rd, hw_trig, cmp_hi, at_hi, at_lo, tick, irq, wake, samp;
   logic sat_hi, sat_lo;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [9:0] trial, target;
   logic [4:0] chan;
   logic [15:0] pins;
   pwr_t pwr;
   int n_fail, samples_checked, n, cnt;
   adc_low_power_mode_control dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pwr_i(pwr), .hw_trig_i(hw_trig),
      .async_tick_i(tick), .cmp_hi_i(cmp_hi), .at_high_ref_i(at_hi), .at_low_ref_i(at_lo),
      .dac_trial_o(trial), .sampling_o(samp), .channel_o(chan), .pin_dig_disable_o(pins),
      .irq_o(irq), .wake_o(wake));
   adc_afe_model afe (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .target_i(target),
      .sat_hi_i(sat_hi), .sat_lo_i(sat_lo), .trial_i(trial), .cmp_hi_o(cmp_hi),
      .at_high_ref_o(at_hi), .at_low_ref_o(at_lo), .async_tick_o(tick));
   task automatic final_report();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic expect_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      d = rdata;
      `CHK(d, e)
   endtask : expect_reg
   task automatic expect_result(input logic [9:0] e);
      expect_reg(ADDR_RES_HI, {6'h00, e[9:8]});
      expect_reg(ADDR_RES_LO, e[7:0]);
   endtask : expect_result
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge core_clk_i);
         n++;
      end
      #1;
   endtask : wait_irq
   // fixed span long enough for a long-sample conversion
   task automatic start(input logic [7:0] v);
      wr_reg(ADDR_SC1, v);
      cnt = 0;
      #1;
      repeat (120) begin
         if (samp === 1'b1) cnt++;
         @(posedge core_clk_i);
         #1;
      end
   endtask : start
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_fail++;
      final_report();
   end
   initial begin
      nrst_i = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      hw_trig = 1'b0;
      pwr = '0;
      sat_hi = 1'b0;
      sat_lo = 1'b0;
      target = 10'h2A5;
      n_fail = 0;
      samples_checked = 0;
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      expect_reg(ADDR_CFG, 8'h00);
      expect_reg(ADDR_SC2, 8'h00);
      expect_reg(ADDR_SC1, 8'h1F);
      expect_reg(4'hF, 8'h00);
      `CHK(chan, 5'h1F)
      wr_reg(ADDR_CFG, 8'h98);
      expect_reg(ADDR_CFG, 8'h98);
      wr_reg(ADDR_SC2, 8'h7C);
      expect_reg(ADDR_SC2, 8'h70);
      wr_reg(ADDR_SC2, 8'h00);
      wr_reg(ADDR_PIN_ONE, 8'h02);
      #1;
      `CHK(pins, 16'h0002)
      start(8'h41);
      `CHK(cnt, 24)
      `CHK(chan, 5'h01)
      `CHK(irq, 1'b1)
      expect_reg(ADDR_SC1, 8'hC1);
      expect_result(10'h2A5);
      `CHK(irq, 1'b0)
      repeat (60) @(posedge core_clk_i);
      #1;
      `CHK(irq, 1'b0)
      // channel 0 has its pin control clear
      wr_reg(ADDR_CFG, 8'h08);
      target <= 10'h0C3;
      start(8'h40);
      `CHK(cnt, 4)
      expect_result(10'h0C3);
      // divide by two: each sample tick takes two bus cycles
      wr_reg(ADDR_CFG, 8'h28);
      start(8'h40);
      `CHK(cnt, 8)
      target <= 10'h155;
      wr_reg(ADDR_SC1, 8'h41);
      expect_reg(ADDR_SC2, 8'h80);
      pwr.stop3 <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      expect_reg(ADDR_SC2, 8'h00);
      pwr.stop3 <= 1'b0;
      repeat (100) @(posedge core_clk_i);
      expect_reg(ADDR_SC1, 8'h41);
      expect_result(10'h0C3);
      wr_reg(ADDR_CFG, 8'h0B);
      target <= 10'h3A1;
      wr_reg(ADDR_SC1, 8'h41);
      pwr.stop3 <= 1'b1;
      wait_irq(300);
      `CHK(wake, 1'b1)
      expect_result(10'h3A1);
      wr_reg(ADDR_SC2, 8'h40);
      wr_reg(ADDR_SC1, 8'h41);
      repeat (150) @(posedge core_clk_i);
      #1;
      `CHK(irq, 1'b0)
      hw_trig <= 1'b1;
      wait_irq(300);
      `CHK(wake, 1'b1)
      hw_trig <= 1'b0;
      pwr.stop3 <= 1'b0;
      expect_result(10'h3A1);
      wr_reg(ADDR_SC2, 8'h00);
      for (int i = 0; i < 3; i++) begin
         sat_hi <= (i != 2);
         sat_lo <= (i == 2);
         wr_reg(ADDR_CFG, (i == 1) ? 8'h00 : 8'h08);
         start(8'h41);
         expect_result((i == 0) ? FULL_10 : (i == 1) ? FULL_8 : ZERO_CODE);
      end
      sat_lo <= 1'b0;
      target <= 10'h100;
      wr_reg(ADDR_CMP_HI, 8'h02);
      wr_reg(ADDR_CMP_LO, 8'h00);
      wr_reg(ADDR_SC2, 8'h30);
      start(8'h41);
      expect_reg(ADDR_SC1, 8'h41);
      target <= 10'h300;
      start(8'h41);
      expect_reg(ADDR_SC1, 8'hC1);
      wr_reg(ADDR_SC2, 8'h00);
      start(8'h5F);
      `CHK(cnt, 0)
      target <= 10'h2A5;
      start(8'h41);
      expect_reg(ADDR_RES_HI, 8'h02);
      target <= 10'h05A;
      start(8'h41);
      expect_reg(ADDR_SC1, 8'h41);
      expect_reg(ADDR_RES_LO, 8'hA5);
      pwr.deep_stop <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      pwr.deep_stop <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      expect_reg(ADDR_CFG, 8'h00);
      expect_reg(ADDR_SC1, 8'h1F);
      `CHK(pins, 16'h0000)
      wr_reg(ADDR_CFG, 8'h08);
      wr_reg(ADDR_SC2, 8'h00);
      target <= 10'h1E7;
      start(8'h41);
      expect_result(10'h1E7);
      final_report();
   end
endmodule : adc_low_power_mode_control_test
`default_nettype wire
